// ==== usfc_top.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - Transmit FIFO entry count readable, 16 bits, zero after reset.
// - Receive FIFO entry count readable, 16 bits, zero after reset.
// - Writing bit 2 empties transmit FIFO; bit self-clears, same as FIFO control bit.
// - Writing bit 1 empties receive FIFO; bit self-clears.
// - Writing bit 0 resets controller at once, release is clock-synchronous.
// - Shadow request-to-send is modem control bit; drives active-low request output.
// - Without auto flow or loopback, request output low whenever request bit is high.
// - Auto flow with FIFOs: request output high while receive fill at or above trigger.
// - Loopback holds request output high and loops request bit to modem input.
// - Shadow break is line control bit; forces transmit line low outside loopback.
// - Infrared mode with break set pulses the infrared output continuously.
// - Loopback keeps break off the pin and loops it into the receiver.
// - Shadow DMA mode is FIFO control bit; selects request signalling mode.
// - Shadow bits reset to zero, sit at bit 0, upper bits read zero.
// - Two-bit receive trigger sets rx data-available and DMA request level.

// Plain synchronous FIFO with a synchronous clear
module usfc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32,
	parameter int CW = $clog2(DEPTH + 1)
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic inValid,
	input wire logic [WIDTH-1:0] inData,
	output logic inReady,
	output logic outValid,
	output logic [WIDTH-1:0] outData,
	input wire logic outReady,
	output logic [CW-1:0] count
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr;
	logic [AW-1:0] rdPtr;
	logic push;
	logic pop;

	// Honest full and empty straight from the count
	assign inReady = (count != CW'(DEPTH));
	assign outValid = (count != '0);
	assign outData = mem[rdPtr];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	// Storage; no reset needed on data
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wrPtr] <= inData;
		end
	end

	// Pointers and level; clear only resets control, data is left stale
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end else if (clear) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
			end
			if (pop) begin
				rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
			end
			count <= count + CW'(push) - CW'(pop);
		end
	end
endmodule

module usfc_top #(
	parameter int DEPTH = usfc_pkg::FIFO_DEPTH,
	parameter int CW = $clog2(DEPTH + 1)
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [usfc_pkg::ADDR_W-1:0] addr,
	input wire logic [usfc_pkg::DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [usfc_pkg::DATA_W-1:0] rdata,
	output logic [usfc_pkg::CHAR_W-1:0] txData,
	output logic txValid,
	input wire logic txReady,
	input wire logic [usfc_pkg::CHAR_W-1:0] rxData,
	input wire logic rxValid,
	output logic rxReady,
	input wire logic serialIn,
	input wire logic sirIn_n,
	output logic txLine,
	output logic sirOut_n,
	output logic rts_n,
	output logic loopRequest,
	output logic loopBreak,
	output logic rxDataAvail,
	output logic dmaTxReq_n,
	output logic dmaRxReq_n,
	output logic ctrlRst_n
);
	import usfc_pkg::*;

	logic softHold;
	logic rstAsync_n;
	logic rstMeta;
	usfc_rst_t rstState;
	logic rtsBit;
	logic breakBit;
	usfc_dma_t dmaMode;
	logic [CTL_W-1:0] ctrl;
	logic txClr;
	logic rxClr;
	logic [CW-1:0] txCount;
	logic [CW-1:0] rxCount;
	logic txInReady;
	logic rxOutValid;
	logic [CHAR_W-1:0] rxOutData;
	logic fifoEn;
	logic loopMode;
	logic autoFlow;
	logic sirMode;
	logic [1:0] rxTrigger;
	logic rxAtTrigger;
	logic rxPop;
	logic txPush;
	logic [$clog2(SIR_HALF_CYCLES)-1:0] sirDiv;
	logic sirTick;
	logic sirPhase;

	// Address compare, used by every decoder below
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
		return a == ofs;
	endfunction

	// Receive trigger level: one char, quarter, half, two less than full
	function automatic logic [CW-1:0] trigLevel(input logic [1:0] sel);
		case (sel)
			2'h0: trigLevel = CW'(1);
			2'h1: trigLevel = CW'(DEPTH / 4);
			2'h2: trigLevel = CW'(DEPTH / 2);
			default: trigLevel = CW'(DEPTH - 2);
		endcase
	endfunction

	assign fifoEn = ctrl[CTL_FIFO_EN_BIT];
	assign loopMode = ctrl[CTL_LOOP_BIT];
	assign autoFlow = ctrl[CTL_AUTOFLOW_BIT];
	assign sirMode = ctrl[CTL_SIR_BIT];
	assign rxTrigger = ctrl[CTL_TRIG_LSB +: 2];
	assign rxAtTrigger = (rxCount >= trigLevel(rxTrigger));
	assign rxPop = rd && hit(addr, RX_DATA_OFS) && rxOutValid;
	assign txPush = wr && hit(addr, TX_DATA_OFS);

	// Soft reset request, one cycle per write; only the pin reset resets it, so it survives its own effect
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			softHold <= 1'b0;
		end else begin
			softHold <= wr && hit(addr, SOFT_RST_OFS) && wdata[SOFT_RST_BIT];
		end
	end

	// Assert at once, release on the third clock edge through rstMeta and rstState
	assign rstAsync_n = rst_n && !softHold;

	always_ff @(posedge clk or negedge rstAsync_n) begin
		if (!rstAsync_n) begin
			rstMeta <= 1'b0;
			rstState <= RST_HOLD;
		end else begin
			rstMeta <= 1'b1;
			case (rstState)
				RST_HOLD: rstState <= rstMeta ? RST_SYNC : RST_HOLD;
				RST_SYNC: rstState <= RST_RUN;
				default: rstState <= RST_RUN;
			endcase
		end
	end

	assign ctrlRst_n = (rstState == RST_RUN);

	// Shadow bits are the control bits themselves, so no copy can go stale
	always_ff @(posedge clk or negedge ctrlRst_n) begin
		if (!ctrlRst_n) begin
			rtsBit <= MIRROR_RST;
			breakBit <= MIRROR_RST;
			dmaMode <= DMA_SINGLE;
		end else if (wr) begin
			if (hit(addr, RTS_MIRROR_OFS)) begin
				rtsBit <= wdata[MIRROR_BIT];
			end else if (hit(addr, BREAK_MIRROR_OFS)) begin
				breakBit <= wdata[MIRROR_BIT];
			end else if (hit(addr, DMA_MIRROR_OFS)) begin
				dmaMode <= usfc_dma_t'(wdata[MIRROR_BIT]);
			end
		end
	end

	// Line setup: FIFO enable, loopback, auto flow, infrared, rx trigger
	always_ff @(posedge clk or negedge ctrlRst_n) begin
		if (!ctrlRst_n) begin
			ctrl <= CTRL_RST;
		end else if (wr && hit(addr, LINE_CTRL_OFS)) begin
			ctrl <= wdata[CTL_W-1:0];
		end
	end

	// FIFO clear strobes last one cycle and never read back as one
	always_ff @(posedge clk or negedge ctrlRst_n) begin
		if (!ctrlRst_n) begin
			txClr <= 1'b0;
			rxClr <= 1'b0;
		end else begin
			txClr <= wr && hit(addr, SOFT_RST_OFS) && wdata[TX_CLR_BIT];
			rxClr <= wr && hit(addr, SOFT_RST_OFS) && wdata[RX_CLR_BIT];
		end
	end

	// Transmit path: writes beyond full are dropped, as on a real port
	usfc_fifo #(.WIDTH(CHAR_W), .DEPTH(DEPTH), .CW(CW)) txFifo (
		.clk(clk),
		.rst_n(ctrlRst_n),
		.clear(txClr),
		.inValid(txPush),
		.inData(wdata[CHAR_W-1:0]),
		.inReady(txInReady),
		.outValid(txValid),
		.outData(txData),
		.outReady(txReady),
		.count(txCount)
	);

	// Receive path; rxReady low stalls the receiver when full
	usfc_fifo #(.WIDTH(CHAR_W), .DEPTH(DEPTH), .CW(CW)) rxFifo (
		.clk(clk),
		.rst_n(ctrlRst_n),
		.clear(rxClr),
		.inValid(rxValid),
		.inData(rxData),
		.inReady(rxReady),
		.outValid(rxOutValid),
		.outData(rxOutData),
		.outReady(rxPop),
		.count(rxCount)
	);

	// Read data one cycle after the strobe, zero otherwise and for holes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= '0;
		end else if (!rd) begin
			rdata <= '0;
		end else if (hit(addr, TX_FILL_OFS)) begin
			rdata <= DATA_W'(txCount);
		end else if (hit(addr, RX_FILL_OFS)) begin
			rdata <= DATA_W'(rxCount);
		end else if (hit(addr, RTS_MIRROR_OFS)) begin
			rdata <= DATA_W'(rtsBit);
		end else if (hit(addr, BREAK_MIRROR_OFS)) begin
			rdata <= DATA_W'(breakBit);
		end else if (hit(addr, DMA_MIRROR_OFS)) begin
			rdata <= DATA_W'(dmaMode);
		end else if (hit(addr, LINE_CTRL_OFS)) begin
			rdata <= DATA_W'(ctrl);
		end else if (hit(addr, RX_DATA_OFS)) begin
			rdata <= DATA_W'(rxOutData);
		end else begin
			rdata <= '0;
		end
	end

	// Infrared break pulse rate, a tick every SIR_HALF_CYCLES
	always_ff @(posedge clk or negedge ctrlRst_n) begin
		if (!ctrlRst_n) begin
			sirDiv <= '0;
			sirPhase <= 1'b0;
		end else if (sirTick) begin
			sirDiv <= '0;
			sirPhase <= !sirPhase;
		end else begin
			sirDiv <= sirDiv + 1'b1;
		end
	end

	assign sirTick = (sirDiv == $bits(sirDiv)'(SIR_HALF_CYCLES - 1));

	// Pins are registered so they never glitch on control changes
	always_ff @(posedge clk or negedge ctrlRst_n) begin
		if (!ctrlRst_n) begin
			rts_n <= 1'b1;
			txLine <= 1'b1;
			sirOut_n <= 1'b1;
			loopRequest <= 1'b0;
			loopBreak <= 1'b0;
		end else begin
			if (loopMode) begin
				rts_n <= 1'b1;
			end else if (autoFlow && fifoEn && rxAtTrigger) begin
				rts_n <= 1'b1;
			end else begin
				rts_n <= !rtsBit;
			end
			txLine <= loopMode ? 1'b1 : (serialIn && !breakBit);
			if (loopMode) begin
				sirOut_n <= 1'b1;
			end else if (sirMode && breakBit) begin
				sirOut_n <= sirPhase;
			end else begin
				sirOut_n <= sirIn_n;
			end
			loopRequest <= loopMode && rtsBit;
			loopBreak <= loopMode && breakBit;
		end
	end

	// DMA requests; single mode ignores the FIFO thresholds
	always_ff @(posedge clk or negedge ctrlRst_n) begin
		if (!ctrlRst_n) begin
			dmaTxReq_n <= 1'b1;
			dmaRxReq_n <= 1'b1;
			rxDataAvail <= 1'b0;
		end else begin
			rxDataAvail <= fifoEn ? rxAtTrigger : (rxCount != '0);
			if (dmaMode == DMA_MULTI && fifoEn) begin
				dmaTxReq_n <= !txInReady;
				dmaRxReq_n <= !rxAtTrigger;
			end else begin
				dmaTxReq_n <= (txCount != '0);
				dmaRxReq_n <= (rxCount == '0);
			end
		end
	end

	sequence s_rtsWrite1;
		wr && hit(addr, RTS_MIRROR_OFS) && wdata[MIRROR_BIT];
	endsequence

	sequence s_plainLine;
		!loopMode && !autoFlow && !(wr && hit(addr, LINE_CTRL_OFS));
	endsequence

	property p_txFill;
		@(posedge clk) disable iff (!ctrlRst_n)
		rd && hit(addr, TX_FILL_OFS) |=> rdata == DATA_W'($past(txCount));
	endproperty
	a_txFill: assert property (p_txFill) else $error("tx fill read wrong");

	property p_rxFill;
		@(posedge clk) disable iff (!ctrlRst_n)
		rd && hit(addr, RX_FILL_OFS) |=> rdata[DATA_W-1:FIELD_W] == '0 && rdata == DATA_W'($past(rxCount));
	endproperty
	a_rxFill: assert property (p_rxFill) else $error("rx fill read wrong");

	property p_txClear;
		@(posedge clk) disable iff (!ctrlRst_n)
		wr && hit(addr, SOFT_RST_OFS) && wdata[TX_CLR_BIT] && !wdata[SOFT_RST_BIT] |=> ##1 txCount == '0;
	endproperty
	a_txClear: assert property (p_txClear) else $error("tx fifo not emptied");

	property p_rxClrSelf;
		@(posedge clk) disable iff (!ctrlRst_n)
		rxClr |=> !rxClr || $past(wr);
	endproperty
	a_rxClrSelf: assert property (p_rxClrSelf) else $error("rx clear stuck");

	property p_softReset;
		@(posedge clk) disable iff (!rst_n)
		softHold |-> !ctrlRst_n ##1 !ctrlRst_n ##1 !ctrlRst_n;
	endproperty
	a_softReset: assert property (p_softReset) else $error("soft reset not held");

	property p_rtsDrive;
		@(posedge clk) disable iff (!ctrlRst_n)
		s_rtsWrite1 ##1 s_plainLine |=> !rts_n;
	endproperty
	a_rtsDrive: assert property (p_rtsDrive) else $error("rts not asserted");

	property p_autoFlow;
		@(posedge clk) disable iff (!ctrlRst_n)
		autoFlow && fifoEn && rxAtTrigger |=> rts_n;
	endproperty
	a_autoFlow: assert property (p_autoFlow) else $error("rts not gated");

	property p_loopRts;
		@(posedge clk) disable iff (!ctrlRst_n)
		loopMode |=> rts_n && loopRequest == $past(rtsBit);
	endproperty
	a_loopRts: assert property (p_loopRts) else $error("loopback rts wrong");

	property p_break;
		@(posedge clk) disable iff (!ctrlRst_n)
		breakBit && !loopMode |=> !txLine;
	endproperty
	a_break: assert property (p_break) else $error("break not on line");

	property p_sirPulse;
		@(posedge clk) disable iff (!ctrlRst_n)
		sirMode && breakBit && !loopMode && sirTick ##1 (sirMode && breakBit && !loopMode) |=> $changed(sirOut_n);
	endproperty
	a_sirPulse: assert property (p_sirPulse) else $error("sir not pulsing");

	property p_loopBreak;
		@(posedge clk) disable iff (!ctrlRst_n)
		loopMode && breakBit |=> txLine && loopBreak;
	endproperty
	a_loopBreak: assert property (p_loopBreak) else $error("break leaked in loopback");

	property p_dmaSingle;
		@(posedge clk) disable iff (!ctrlRst_n)
		dmaMode == DMA_SINGLE && rxCount != '0 |=> !dmaRxReq_n;
	endproperty
	a_dmaSingle: assert property (p_dmaSingle) else $error("rx dma request missing");

	property p_mirrorRead;
		@(posedge clk) disable iff (!ctrlRst_n)
		rd && hit(addr, BREAK_MIRROR_OFS) |=> rdata == DATA_W'($past(breakBit));
	endproperty
	a_mirrorRead: assert property (p_mirrorRead) else $error("break mirror read wrong");

	property p_trigger;
		@(posedge clk) disable iff (!ctrlRst_n)
		fifoEn && rxCount == CW'(DEPTH - 2) |=> rxDataAvail;
	endproperty
	a_trigger: assert property (p_trigger) else $error("trigger level missed");
endmodule

// ==== usfc_pkg.sv ====
package usfc_pkg;
	// Bus shape
	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int FIELD_W = 16;
	// Register byte addresses
	localparam logic [31:0] TX_FILL_OFS = 32'h50001080;
	localparam logic [31:0] RX_FILL_OFS = 32'h50001084;
	localparam logic [31:0] SOFT_RST_OFS = 32'h50001088;
	localparam logic [31:0] RTS_MIRROR_OFS = 32'h5000108c;
	localparam logic [31:0] BREAK_MIRROR_OFS = 32'h50001090;
	localparam logic [31:0] DMA_MIRROR_OFS = 32'h50001094;
	localparam logic [31:0] LINE_CTRL_OFS = 32'h500010c0;
	localparam logic [31:0] TX_DATA_OFS = 32'h500010c4;
	localparam logic [31:0] RX_DATA_OFS = 32'h500010c8;
	// Field positions
	localparam int TX_CLR_BIT = 2;
	localparam int RX_CLR_BIT = 1;
	localparam int SOFT_RST_BIT = 0;
	localparam int MIRROR_BIT = 0;
	localparam int CTL_FIFO_EN_BIT = 0;
	localparam int CTL_LOOP_BIT = 1;
	localparam int CTL_AUTOFLOW_BIT = 2;
	localparam int CTL_SIR_BIT = 3;
	localparam int CTL_TRIG_LSB = 4;
	localparam int CTL_W = 6;
	// Reset values
	localparam logic MIRROR_RST = 1'b0;
	localparam logic [CTL_W-1:0] CTRL_RST = 6'h00;
	// Sizing and timing
	localparam int FIFO_DEPTH = 32;
	localparam int CHAR_W = 8;
	localparam int SIR_HALF_CYCLES = 8;
	typedef enum logic {DMA_SINGLE, DMA_MULTI} usfc_dma_t;
	typedef enum logic [1:0] {RST_HOLD, RST_SYNC, RST_RUN} usfc_rst_t;
endpackage

// ==== usfc_peer_model.sv ====
`timescale 1ns/1ps
// Line-side peer: sink for transmitted characters, source of received ones
module usfc_peer_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [usfc_pkg::CHAR_W-1:0] txData,
	input wire logic txValid,
	output logic txReady,
	output logic [usfc_pkg::CHAR_W-1:0] rxData,
	output logic rxValid,
	input wire logic rxReady,
	output logic serialIn,
	output logic sirIn_n,
	input wire logic drain,
	input wire logic offer,
	output logic [usfc_pkg::CHAR_W-1:0] lastTx
);
	import usfc_pkg::*;
	logic [CHAR_W-1:0] nextRx = 8'h00;
	// Quiet line: marking level on both serial paths
	assign serialIn = 1'b1;
	assign sirIn_n = 1'b1;
	// Sink takes characters only while told to drain, so the queue can back up
	initial txReady = 1'b0;
	initial lastTx = 8'h00;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			txReady <= 1'b0;
			lastTx <= 8'h00;
		end else begin
			txReady <= drain;
			if (txValid && txReady)
				lastTx <= txData; // Taken at the edge that sees both high
		end
	end
	// Source holds a character until it is accepted; idle data keeps changing
	initial rxValid = 1'b0;
	initial rxData = 8'hff;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rxValid <= 1'b0;
			rxData <= 8'hff;
			nextRx <= 8'h00;
		end else if (!rxValid || rxReady) begin
			rxValid <= offer;
			rxData <= offer ? nextRx : ~rxData; // No stale value once released
			if (offer)
				nextRx <= nextRx + 8'h01;
		end
	end
endmodule

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
	import usfc_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [ADDR_W-1:0] addr = '0;
	logic [DATA_W-1:0] wdata = '0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [DATA_W-1:0] rdata;
	logic [CHAR_W-1:0] txData, rxData, lastTx;
	logic txValid, txReady, rxValid, rxReady, serialIn, sirIn_n, txLine, sirOut_n, rts_n;
	logic loopRequest, loopBreak, rxDataAvail, dmaTxReq_n, dmaRxReq_n, ctrlRst_n;
	logic drain = 1'b0;
	logic offer = 1'b0;
	logic prevSir;
	int n_fail = 0;
	int checks = 0;
	int n;
	localparam logic [31:0] MAP [7] = '{TX_FILL_OFS, RX_FILL_OFS, SOFT_RST_OFS, RTS_MIRROR_OFS,
		BREAK_MIRROR_OFS, DMA_MIRROR_OFS, 32'h500010fc};

	// 25 MHz
	always #20 clk = ~clk;

	usfc_top u_usfc_top (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .txData(txData), .txValid(txValid), .txReady(txReady), .rxData(rxData),
		.rxValid(rxValid), .rxReady(rxReady), .serialIn(serialIn), .sirIn_n(sirIn_n),
		.txLine(txLine), .sirOut_n(sirOut_n), .rts_n(rts_n), .loopRequest(loopRequest),
		.loopBreak(loopBreak), .rxDataAvail(rxDataAvail), .dmaTxReq_n(dmaTxReq_n),
		.dmaRxReq_n(dmaRxReq_n), .ctrlRst_n(ctrlRst_n));

	usfc_peer_model u_usfc_peer_model (.clk(clk), .rst_n(rst_n), .txData(txData),
		.txValid(txValid), .txReady(txReady), .rxData(rxData), .rxValid(rxValid),
		.rxReady(rxReady), .serialIn(serialIn), .sirIn_n(sirIn_n), .drain(drain),
		.offer(offer), .lastTx(lastTx));

	task automatic conclude();
		if (n_fail == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic cmpv(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t word %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmpb(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t pin %b expected %b", $time, got, exp);
		end
	endtask

	// Write strobe for one cycle, then two spare cycles so registered pins catch up
	task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
		@(posedge clk);
	endtask

	// Answer is taken once settled inside its only valid cycle, not at a launching edge
	task automatic chk_reg(input logic [31:0] a, input logic [31:0] exp);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		cmpv(rdata, exp);
		@(posedge clk);
	endtask

	// Bounded wait for the controller to leave reset
	task automatic wait_rst();
		repeat (20) if (ctrlRst_n !== 1'b1) @(posedge clk);
		cmpb(ctrlRst_n, 1'b1);
	endtask

	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		wait_rst();
		// Fill, clear and mirror words read zero out of reset, the unmapped one too
		for (int i = 0; i < 7; i++)
			chk_reg(MAP[i], 32'h0);
		cmpb(rts_n, 1'b1);
		cmpb(txLine, 1'b1);
		cmpb(dmaTxReq_n, 1'b0);
		cmpb(dmaRxReq_n, 1'b1);
		// Overfill transmit queue while the line side stalls
		for (int i = 0; i <= FIFO_DEPTH; i++)
			wr_reg(TX_DATA_OFS, 32'(i));
		chk_reg(TX_FILL_OFS, 32'(FIFO_DEPTH));
		cmpb(dmaTxReq_n, 1'b1);
		wr_reg(SOFT_RST_OFS, 32'h4);
		chk_reg(TX_FILL_OFS, 32'h0);
		chk_reg(SOFT_RST_OFS, 32'h0);
		cmpb(txValid, 1'b0);
		for (int i = 0; i < 3; i++)
			wr_reg(TX_DATA_OFS, 32'ha0 + 32'(i));
		drain <= 1'b1;
		repeat (8) @(posedge clk);
		drain <= 1'b0;
		cmpv(32'(lastTx), 32'ha2);
		chk_reg(TX_FILL_OFS, 32'h0);
		// Mirrors keep only bit 0 of an all-ones write
		for (int i = 3; i < 6; i++) begin
			wr_reg(MAP[i], 32'hffffffff);
			chk_reg(MAP[i], 32'h1);
		end
		cmpb(rts_n, 1'b0);
		cmpb(txLine, 1'b0);
		// Auto flow, FIFOs on, trigger two short of full; fill until refused
		wr_reg(LINE_CTRL_OFS, 32'h35);
		offer <= 1'b1;
		repeat (80) if (rxReady === 1'b1) @(posedge clk);
		offer <= 1'b0;
		cmpb(rxReady, 1'b0);
		@(posedge clk);
		@(posedge clk);
		chk_reg(RX_FILL_OFS, 32'(FIFO_DEPTH));
		cmpb(rts_n, 1'b1);
		cmpb(dmaRxReq_n, 1'b0);
		cmpb(rxDataAvail, 1'b1);
		// Held character slips in after the first pop
		for (int i = 0; i < 4; i++)
			chk_reg(RX_DATA_OFS, 32'(i));
		chk_reg(RX_FILL_OFS, 32'(FIFO_DEPTH - 3));
		cmpb(rts_n, 1'b0);
		cmpb(dmaRxReq_n, 1'b1);
		cmpb(rxDataAvail, 1'b0);
		wr_reg(LINE_CTRL_OFS, 32'h25);
		cmpb(rxDataAvail, 1'b1);
		wr_reg(SOFT_RST_OFS, 32'h2);
		chk_reg(RX_FILL_OFS, 32'h0);
		// Loopback keeps request and break off the pins
		wr_reg(LINE_CTRL_OFS, 32'h02);
		cmpb(rts_n, 1'b1);
		cmpb(loopRequest, 1'b1);
		cmpb(txLine, 1'b1);
		cmpb(loopBreak, 1'b1);
		// Infrared with break: one toggle per eight cycles
		wr_reg(LINE_CTRL_OFS, 32'h08);
		cmpb(txLine, 1'b0);
		n = 0;
		prevSir = sirOut_n;
		repeat (32) begin
			@(posedge clk);
			if (sirOut_n !== prevSir)
				n++;
			prevSir = sirOut_n;
		end
		cmpv(32'(n), 32'h4);
		wr_reg(BREAK_MIRROR_OFS, 32'h0);
		cmpb(txLine, 1'b1);
		cmpb(sirOut_n, 1'b1);
		// Controller reset drops at once and returns the request mirror, line control and request pin to defaults
		wr_reg(SOFT_RST_OFS, 32'h1);
		cmpb(ctrlRst_n, 1'b0);
		wait_rst();
		chk_reg(RTS_MIRROR_OFS, 32'h0);
		chk_reg(LINE_CTRL_OFS, 32'h0);
		cmpb(rts_n, 1'b1);
		conclude();
	end

	// Sequence needs well under a thousand cycles
	initial begin
		#400000;
		n_fail++;
		conclude();
	end
endmodule
